//--- crps_chipset.sv
// Purpose: Chipset end driving straps, reset and management requests
// Assumes: Software sets ratio before releasing reset
// Notes:   Register read data valid one cycle after read strobe
`timescale 1ns/1ps
module crps_chipset
  import crps_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  crps_if.chipset         link,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  input  wire logic       snoop,
  output logic [7:0]      rdata
);
  logic [7:0] ctrl;
  logic       grant_seen;
  logic       snoop_q;

  wire wr_ctrl = wr && (addr == REG_CTRL);
  wire wr_stat = wr && (addr == REG_STAT);
  wire [7:0] stat_word = {4'h0, !link.snoop_ack, grant_seen,
                          link.stop_grant, !link.mgmt_mode_active_n};
  wire [7:0] rd_mux = (addr == REG_CTRL)  ? ctrl :
                      (addr == REG_STAT)  ? stat_word :
                      (addr == REG_STRAP) ? {6'h0, ctrl[CTRL_RHI],
                                             ctrl[CTRL_RLO]} : 8'h00;

  // Management request bit self-clears so the pin pulses once
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      // reset straps avoid one half code
      ctrl <= CTRL_RESET_VAL;
    end else if (wr_ctrl) begin
      // straps frozen while out of reset
      ctrl <= ctrl[CTRL_RESET] ? wdata :
              {wdata[7], ctrl[6:5], wdata[4:0]};
    end else begin
      ctrl[CTRL_MGMT] <= 1'b0;
    end
  end

  // Grant flag: set wins over software clear
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      grant_seen <= 1'b0;
      snoop_q    <= 1'b0;
      rdata      <= 8'h00;
    end else begin
      grant_seen <= link.stop_grant || (grant_seen && !wr_stat);
      snoop_q    <= snoop;
      rdata      <= rd ? rd_mux : 8'h00;
    end
  end

  assign link.cpu_reset        = ctrl[CTRL_RESET];
  assign link.mgmt_irq_n       = !ctrl[CTRL_MGMT];
  assign link.stop_clock_req_n = !ctrl[CTRL_STOP];
  // mode inputs held through reset fall
  assign link.flush_n          = !ctrl[CTRL_FLUSH];
  assign link.init             = ctrl[CTRL_INIT];
  // software picks the one specified ratio
  assign link.ratio_strap_lo   = ctrl[CTRL_RLO];
  assign link.ratio_strap_hi   = ctrl[CTRL_RHI];
  assign link.straps_driven    = !ctrl[CTRL_BOUNDARY];
  assign link.snoop_req        = snoop_q;
endmodule : crps_chipset

//--- crps_cpu.sv
// Purpose: Processor end of the reset and power sideband
// Assumes: Chipset keeps straps stable once reset is released
// Notes:   Execution is modelled by an instruction boundary pulse
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
module crps_cpu
  import crps_pkg::*;
#(
  parameter int LINES = CACHE_LINES
) (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  crps_if.cpu             link,
  input  wire logic       insn_boundary,
  input  wire logic       higher_irq,
  input  wire logic       mgmt_exit,
  input  wire logic       line_fill,
  input  wire logic [3:0] line_idx,
  input  wire logic       line_dirty,
  output logic            core_clk_en,
  output logic [1:0]      test_mode,
  output logic [7:0]      bus_core_ratio,
  output logic [LINES-1:0] line_valid,
  output logic            writeback_req,
  output logic            mgmt_pending,
  output logic            core_at_start
);
  typedef enum logic [1:0] {CRPS_RUN, CRPS_GRANT, CRPS_STOPPED} crps_st_e;

  crps_st_e         state;
  crps_st_e         next_state;
  logic             reset_q;
  logic             in_mgmt;
  logic [1:0]       strap_code;
  logic [LINES-1:0] line_dirty_q;
  logic [1:0]       grant_cnt;

  wire reset_fall   = reset_q && !link.cpu_reset;
  wire stop_req     = !link.stop_clock_req_n;
  wire running      = (state == CRPS_RUN) && !link.cpu_reset;
  wire take_mgmt    = running && insn_boundary && mgmt_pending;
  wire take_stop    = running && insn_boundary && stop_req && !take_mgmt &&
                      !higher_irq;
  // floating straps read as one half
  wire [1:0] strap_in = link.straps_driven ?
                        {link.ratio_strap_hi, link.ratio_strap_lo} :
                        RATIO_CODE_1_2;

  always_comb begin
    next_state = state;
    unique case (state)
      CRPS_RUN:     if (take_stop) next_state = CRPS_GRANT;
      CRPS_GRANT:   if (grant_cnt == 2'(GRANT_CYCLES - 1))
                      next_state = CRPS_STOPPED;
      CRPS_STOPPED: if (!stop_req) next_state = CRPS_RUN;
    endcase
  end

  always_comb begin
    unique case (strap_code)
      RATIO_CODE_1_3: bus_core_ratio = RATIO_1_3;
      RATIO_CODE_2_5: bus_core_ratio = RATIO_2_5;
      RATIO_CODE_1_2: bus_core_ratio = RATIO_1_2;
      RATIO_CODE_2_7: bus_core_ratio = RATIO_2_7;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reset_q <= 1'b1;
    end else begin
      reset_q <= link.cpu_reset;
    end
  end

  // straps caught at reset release only
  // mode taken from flush and init
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      strap_code <= RATIO_CODE_1_2;
      test_mode  <= TMODE_NORMAL;
    end else if (reset_fall) begin
      strap_code <= strap_in;
      test_mode  <= {!link.flush_n, link.init};
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state     <= CRPS_RUN;
      grant_cnt <= 2'h0;
    end else if (link.cpu_reset) begin
      state     <= CRPS_RUN;
      grant_cnt <= 2'h0;
    end else begin
      state     <= next_state;
      grant_cnt <= (state == CRPS_GRANT) ? grant_cnt + 2'h1 : 2'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mgmt_pending <= 1'b0;
      in_mgmt      <= 1'b0;
    end else if (link.cpu_reset) begin
      mgmt_pending <= 1'b0;
      in_mgmt      <= 1'b0;
    end else begin
      mgmt_pending <= !link.mgmt_irq_n || (mgmt_pending && !take_mgmt);
      if (take_mgmt)
        in_mgmt <= 1'b1;
      else if (mgmt_exit && running)
        in_mgmt <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      line_valid   <= '0;
      line_dirty_q <= '0;
    end else if (link.cpu_reset) begin
      line_valid   <= '0;
      line_dirty_q <= '0;
    end else if (line_fill && running) begin
      line_valid[line_idx]   <= 1'b1;
      line_dirty_q[line_idx] <= line_dirty;
    end
  end

  // Writeback only on replacement of a dirty line, never from reset
  assign writeback_req = line_fill && running && !link.cpu_reset &&
                         line_valid[line_idx] && line_dirty_q[line_idx];

  assign core_at_start           = link.cpu_reset || reset_q;
  assign core_clk_en             = (state != CRPS_STOPPED);
  assign link.mgmt_mode_active_n = !in_mgmt;
  assign link.stop_grant         = (state == CRPS_GRANT);
  assign link.snoop_ack          = link.snoop_req && !link.cpu_reset;
endmodule : crps_cpu

//--- crps_if.sv
// Purpose: Sideband wires between processor end and chipset end
// Assumes: Single clock domain
// Notes:   All request lines active low except reset, init, snoop and straps
`timescale 1ns/1ps
interface crps_if;
  logic cpu_reset;
  logic flush_n;
  logic init;
  logic ratio_strap_lo;
  logic ratio_strap_hi;
  logic straps_driven;
  logic mgmt_irq_n;
  logic stop_clock_req_n;
  logic mgmt_mode_active_n;
  logic stop_grant;
  logic snoop_req;
  logic snoop_ack;
  modport cpu (
    input  cpu_reset, flush_n, init, ratio_strap_lo, ratio_strap_hi,
           straps_driven, mgmt_irq_n, stop_clock_req_n, snoop_req,
    output mgmt_mode_active_n, stop_grant, snoop_ack
  );
  modport chipset (
    output cpu_reset, flush_n, init, ratio_strap_lo, ratio_strap_hi,
           straps_driven, mgmt_irq_n, stop_clock_req_n, snoop_req,
    input  mgmt_mode_active_n, stop_grant, snoop_ack
  );
endinterface : crps_if

//--- crps_link_assertions.sv
// Purpose: Concurrent checks on the sideband link wires
// Assumes: One clock domain, nrst asynchronous active low
// Notes:   Grant pulse length fixed at two cycles
`timescale 1ns/1ps
module crps_link_chk (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic cpu_reset,
  input wire logic stop_clock_req_n,
  input wire logic mgmt_mode_active_n,
  input wire logic stop_grant,
  input wire logic snoop_req,
  input wire logic snoop_ack
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence grant_s;
    stop_grant [*2] ##1 !stop_grant;
  endsequence
  a_snoop_served: assert property (
    snoop_req && !cpu_reset |-> snoop_ack) else $error("snoop unanswered");
  a_no_stray_ack: assert property (
    !snoop_req |-> !snoop_ack) else $error("ack without snoop");
  a_reset_no_ack: assert property (
    cpu_reset |-> !snoop_ack) else $error("ack during reset");
  a_grant_two_cyc: assert property (
    $rose(stop_grant) |-> grant_s) else $error("grant length wrong");
  a_grant_needs_stop: assert property (
    $rose(stop_grant) |-> $past(!stop_clock_req_n))
    else $error("grant without request");
  a_reset_clr_mgmt: assert property (
    cpu_reset |=> mgmt_mode_active_n) else $error("mgmt kept in reset");
  a_reset_no_grant: assert property (
    cpu_reset |=> !stop_grant) else $error("grant in reset");
  a_mgmt_beats_stop: assert property (
    $fell(mgmt_mode_active_n) |-> !stop_grant)
    else $error("grant on mgmt entry");
endmodule : crps_link_chk

//--- crps_pkg.sv
// Purpose: Shared constants for the reset and power sideband link
// Assumes: One bus clock at 250 MHz drives both ends
// Notes:   Ratio codes are {hi, lo} strap bits
package crps_pkg;
  localparam logic [1:0] RATIO_CODE_1_3   = 2'h1;
  localparam logic [1:0] RATIO_CODE_2_5   = 2'h0;
  localparam logic [1:0] RATIO_CODE_1_2   = 2'h2;
  localparam logic [1:0] RATIO_CODE_2_7   = 2'h3;
  // Ratio encodings reported to software: numerator, denominator
  localparam logic [7:0] RATIO_1_3        = 8'h13;
  localparam logic [7:0] RATIO_2_5        = 8'h25;
  localparam logic [7:0] RATIO_1_2        = 8'h12;
  localparam logic [7:0] RATIO_2_7        = 8'h27;
  // Reset test mode selection from {flush, init}
  localparam logic [1:0] TMODE_NORMAL     = 2'h0;
  localparam logic [1:0] TMODE_SELF_TEST  = 2'h1;
  localparam logic [1:0] TMODE_CHECKER    = 2'h2;
  localparam logic [1:0] TMODE_TRISTATE   = 2'h3;
  localparam int         CACHE_LINES      = 16;
  localparam int         GRANT_CYCLES     = 2;
  // Host register offsets
  localparam logic [3:0] REG_CTRL         = 4'h0;
  localparam logic [3:0] REG_STAT         = 4'h1;
  localparam logic [3:0] REG_STRAP        = 4'h2;
  // Control bit positions
  localparam int         CTRL_RESET       = 0;
  localparam int         CTRL_MGMT        = 1;
  localparam int         CTRL_STOP        = 2;
  localparam int         CTRL_FLUSH       = 3;
  localparam int         CTRL_INIT        = 4;
  localparam int         CTRL_RLO         = 5;
  localparam int         CTRL_RHI         = 6;
  localparam int         CTRL_BOUNDARY    = 7;
  localparam logic [7:0] CTRL_RESET_VAL   = 8'h01;
endpackage : crps_pkg

//--- testbench.sv
// Purpose: Directed test of both sideband ends joined back to back
// Assumes: Register bus strobes one cycle, read data next cycle
// Notes:   Outputs sampled on the falling edge to avoid races
`timescale 1ns/1ps
module testbench;
  import crps_pkg::*;
  logic       sys_clk, nrst, bnd, hirq, mexit, fill, dirty;
  logic       wr, rd, snoop, clk_en, wbr, mpend, cas;
  logic [3:0] lidx, addr;
  logic [7:0] wdata, rdata, ratio, cv;
  logic [1:0] tmode;
  logic [15:0] lval;
  int         err_total, n_checks;
  crps_if link_i ();
  crps_cpu crps_cpu_inst (.sys_clk(sys_clk), .nrst(nrst), .link(link_i),
    .insn_boundary(bnd), .higher_irq(hirq), .mgmt_exit(mexit),
    .line_fill(fill), .line_idx(lidx), .line_dirty(dirty),
    .core_clk_en(clk_en), .test_mode(tmode), .bus_core_ratio(ratio),
    .line_valid(lval), .writeback_req(wbr), .mgmt_pending(mpend),
    .core_at_start(cas));
  crps_chipset crps_chipset_inst (.sys_clk(sys_clk), .nrst(nrst),
    .link(link_i), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .snoop(snoop), .rdata(rdata));
  crps_link_chk crps_link_chk_inst (.sys_clk(sys_clk), .nrst(nrst),
    .cpu_reset(link_i.cpu_reset), .stop_clock_req_n(link_i.stop_clock_req_n),
    .mgmt_mode_active_n(link_i.mgmt_mode_active_n),
    .stop_grant(link_i.stop_grant), .snoop_req(link_i.snoop_req),
    .snoop_ack(link_i.snoop_ack));
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
    @(posedge sys_clk);
  endtask : wreg
  task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    @(negedge sys_clk);
    chk(rdata, exp);
    @(posedge sys_clk);
  endtask : rreg
  task automatic boundary(input logic hi);
    hirq <= hi;
    bnd  <= 1'b1;
    @(posedge sys_clk);
    bnd  <= 1'b0;
    hirq <= 1'b0;
  endtask : boundary
  task automatic s_reset;
    logic [7:0] er [5];
    er = '{RATIO_2_5, RATIO_1_3, RATIO_1_2, RATIO_2_7, RATIO_1_2};
    for (int i = 0; i < 5; i++) begin
      cv    = {i == 4, i[1:0], i[0], i[1], 3'h1};
      fill  <= 1'b1;
      dirty <= 1'b1;
      lidx  <= 4'(i + 3);
      @(posedge sys_clk);
      fill  <= 1'b0;
      wreg(REG_CTRL, cv);
      @(negedge sys_clk);
      chk(wbr, 1'b0);
      chk(lval, 16'h0000);
      chk(cas, 1'b1);
      @(posedge sys_clk);
      cv[0] = 1'b0;
      wreg(REG_CTRL, cv);
      repeat (3) @(posedge sys_clk);
      wreg(REG_CTRL, cv ^ 8'h78);
      @(negedge sys_clk);
      chk(ratio, er[i]);
      chk(tmode, i[1:0]);
      @(posedge sys_clk);
    end
  endtask : s_reset
  task automatic s_mgmt;
    wreg(REG_CTRL, cv | 8'h02);
    @(negedge sys_clk);
    chk(mpend, 1'b1);
    chk(link_i.mgmt_mode_active_n, 1'b1);
    @(posedge sys_clk);
    boundary(1'b0);
    @(negedge sys_clk);
    chk(link_i.mgmt_mode_active_n, 1'b0);
    chk(mpend, 1'b0);
    @(posedge sys_clk);
    boundary(1'b0);
    rreg(REG_STAT, 8'h09);
    mexit <= 1'b1;
    @(posedge sys_clk);
    mexit <= 1'b0;
    @(negedge sys_clk);
    chk(link_i.mgmt_mode_active_n, 1'b1);
    @(posedge sys_clk);
  endtask : s_mgmt
  task automatic s_stop;
    int k;
    snoop <= 1'b1;
    wreg(REG_CTRL, cv | 8'h04);
    boundary(1'b1);
    repeat (3) @(negedge sys_clk);
    chk(link_i.stop_grant, 1'b0);
    chk(link_i.snoop_ack, 1'b1);
    @(posedge sys_clk);
    boundary(1'b0);
    for (k = 0; k < 20 && link_i.stop_grant !== 1'b1; k++) @(negedge sys_clk);
    if (k == 20) begin
      err_total++;
      stop_test();
    end
    repeat (2) @(negedge sys_clk);
    chk(clk_en, 1'b0);
    chk(link_i.snoop_ack, 1'b1);
    @(posedge sys_clk);
    rreg(REG_STAT, 8'h04);
    rreg(4'hF, 8'h00);
    wreg(REG_CTRL, cv);
    repeat (2) @(negedge sys_clk);
    chk(clk_en, 1'b1);
  endtask : s_stop
  task automatic s_wback;
    @(posedge sys_clk);
    fill  <= 1'b1;
    dirty <= 1'b1;
    lidx  <= 4'h9;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk(wbr, 1'b1);
    @(posedge sys_clk);
    fill  <= 1'b0;
    wreg(REG_CTRL, cv | 8'h01);
    fill  <= 1'b1;
    @(negedge sys_clk);
    chk(wbr, 1'b0);
    chk(lval, 16'h0000);
    @(posedge sys_clk);
    fill  <= 1'b0;
    wreg(REG_CTRL, cv);
  endtask : s_wback
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    {nrst, bnd, hirq, mexit, fill, dirty, wr, rd, snoop} = 9'h000;
    {lidx, addr, wdata} = 16'h0000;
    err_total = 0;
    n_checks  = 0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    s_reset();
    s_mgmt();
    s_stop();
    s_wback();
    stop_test();
  end
endmodule : testbench
